// ### logic/ppk_pkg.sv
// constants, register map and types of the port pin and keypad block
// assumes a 125 MHz cpu clock and an axi4-lite register master
// Function
// - configurable pins come up quasi-bidirectional
// - quasi: very weak pull-up while latch one
// - quasi: weak pull-up while latch and pin one
// - quasi: strong pull-up two clocks on rise
// - quasi: latch zero drives strong pulldown
// - open drain: no pull-ups, pulldown on zero
// - push-pull: strong pull-up on one
// - two mode bits select the pin mode
// - port1 pins 2,3 always open drain
// - port1 pin 5 input only with internal reset
// - crystal option disables port2 pins 0,1
// - strap picks latch reset level, quasi mode
// - per-port schmitt select, fixed pins always schmitt
// - clock out on port2 pin 0 with rc
// - clock out runs at cpu clock / 6
// - timer1 overflow toggles its pin
// - timer0 overflow toggles port1 pin 2
// - port2 pins 0,1 modes from two registers
// - keypad enable bit n selects port0 pin n
// - enabled port0 pin low sets keypad flag
// - only software clears the keypad flag
// - pending keypad interrupt wakes the cpu
package ppk_pkg;

  // ==========================================================
  // sizes
  localparam int NPINS = 24;
  localparam int ADDR_W = 10;
  localparam int IDX_W = 8;

  // ==========================================================
  // register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_P0 = 8'h80;
  localparam logic [IDX_W-1:0] IDX_P0MA = 8'h84;
  localparam logic [IDX_W-1:0] IDX_P0MB = 8'h85;
  localparam logic [IDX_W-1:0] IDX_KPEN = 8'h86;
  localparam logic [IDX_W-1:0] IDX_P1 = 8'h90;
  localparam logic [IDX_W-1:0] IDX_P1MA = 8'h91;
  localparam logic [IDX_W-1:0] IDX_P1MB = 8'h92;
  localparam logic [IDX_W-1:0] IDX_P2 = 8'hA0;
  localparam logic [IDX_W-1:0] IDX_AUX = 8'hA2;
  localparam logic [IDX_W-1:0] IDX_P2MISC = 8'hA4;
  localparam logic [IDX_W-1:0] IDX_P2MB = 8'hA5;
  localparam logic [7:0] REG_RESET = 8'h00;

  // port2_mode_misc fields
  localparam int BIT_SCH2 = 7;
  localparam int BIT_SCH1 = 6;
  localparam int BIT_SCH0 = 5;
  localparam int BIT_CLKO = 4;
  localparam int BIT_TOG1 = 3;
  localparam int BIT_TOG0 = 2;
  // aux_control_reg fields
  localparam int AUX_KFLAG = 1;
  localparam int AUX_KBIE = 0;

  // ==========================================================
  // pin numbering: port p pin n is p*8+n
  localparam int PIN_T1_TOG = 7;
  localparam int PIN_OD_A = 10;
  localparam int PIN_OD_B = 11;
  localparam int PIN_T0_TOG = 10;
  localparam int PIN_RST = 13;
  localparam int PIN_X2 = 16;
  localparam int PIN_X1 = 17;

  // mode codes {sel_a, sel_b}
  localparam logic [1:0] MODE_QUASI = 2'h0;
  localparam logic [1:0] MODE_PUSH = 2'h1;
  localparam logic [1:0] MODE_INPUT = 2'h2;
  localparam logic [1:0] MODE_OD = 2'h3;

  // ==========================================================
  // timing
  localparam logic [1:0] STRONG_PULSE_CLKS = 2'h2;
  localparam int CLKOUT_DIV = 6;
  localparam logic [1:0] CLKOUT_HALF = 2'(CLKOUT_DIV / 2);

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    REG_NONE, REG_P0, REG_P0MA, REG_P0MB, REG_KPEN, REG_P1, REG_P1MA,
    REG_P1MB, REG_P2, REG_AUX, REG_P2MISC, REG_P2MB
  } ppk_reg_t;

endpackage

// ### logic/ppk_drv_if.sv
// carrier between port control and the pad driver decode
// assumes both ends run on the same cpu clock
`timescale 1ns/100ps
interface ppk_drv_if;
  import ppk_pkg::*;
  logic [NPINS-1:0] out_val;
  logic [NPINS-1:0] mode_a;
  logic [NPINS-1:0] mode_b;
  logic [NPINS-1:0] pin_lvl;
  logic [NPINS-1:0] pu_very_weak;
  logic [NPINS-1:0] pu_weak;
  logic [NPINS-1:0] pu_strong;
  logic [NPINS-1:0] pull_down;

  modport ctrl (output out_val, output mode_a, output mode_b, output pin_lvl,
    input pu_very_weak, input pu_weak, input pu_strong, input pull_down);
  modport drv (input out_val, input mode_a, input mode_b, input pin_lvl,
    output pu_very_weak, output pu_weak, output pu_strong, output pull_down);
endinterface

// ### logic/ppk_pin_drv.sv
// pad driver decode for all pins: pull-ups, pulldown, strong pulse
// assumes out_val and modes already carry the fixed-function overrides
`timescale 1ns/100ps
module ppk_pin_drv
  import ppk_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  ppk_drv_if.drv bus
);

  typedef struct packed {
    logic [NPINS-1:0] prev;
    logic [NPINS-1:0][1:0] pulse;
  } ppk_drv_st_t;

  ppk_drv_st_t st;
  ppk_drv_st_t next_st;

  // ==========================================================
  // per-pin mode decode
  always_comb begin
    logic [1:0] mode;
    mode = MODE_QUASI;
    next_st = st;
    for (int i = 0; i < NPINS; i++) begin
      mode = {bus.mode_a[i], bus.mode_b[i]};
      next_st.prev[i] = bus.out_val[i];
      bus.pu_very_weak[i] = 1'b0;
      bus.pu_weak[i] = 1'b0;
      bus.pu_strong[i] = 1'b0;
      bus.pull_down[i] = 1'b0;
      // pulse restarts on each rise, dies at once on a fall
      if (mode != MODE_QUASI || !bus.out_val[i]) begin
        next_st.pulse[i] = 2'h0;
      end else if (!st.prev[i]) begin
        next_st.pulse[i] = STRONG_PULSE_CLKS;
      end else if (st.pulse[i] != 2'h0) begin
        next_st.pulse[i] = st.pulse[i] - 2'h1;
      end
      case (mode)
        MODE_QUASI: begin
          bus.pu_very_weak[i] = bus.out_val[i];
          bus.pu_weak[i] = bus.out_val[i] & bus.pin_lvl[i];
          bus.pu_strong[i] = st.pulse[i] != 2'h0;
          bus.pull_down[i] = !bus.out_val[i];
        end
        MODE_PUSH: begin
          bus.pu_strong[i] = bus.out_val[i];
          bus.pull_down[i] = !bus.out_val[i];
        end
        MODE_OD: bus.pull_down[i] = !bus.out_val[i];
        default: ; // input only: nothing drives
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule

// ### logic/ppk_port_top.sv
// port pin configuration, fixed-function pins and keypad interrupt
// assumes axi4-lite on the cpu clock; pads resolve the pull controls
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/100ps
module ppk_port_top
  import ppk_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NPINS-1:0] pin_in,
  output logic [NPINS-1:0] pin_out,
  output logic [NPINS-1:0] pin_oe,
  output logic [NPINS-1:0] pu_very_weak,
  output logic [NPINS-1:0] pu_weak,
  output logic [NPINS-1:0] pin_in_en,
  output logic [NPINS-1:0] pin_schmitt,
  input wire logic timer0_ovf,
  input wire logic timer1_ovf,
  input wire logic port_reset_level_sel,
  input wire logic osc_crystal_sel,
  input wire logic osc_rc_sel,
  input wire logic int_reset_sel,
  output logic keypad_irq,
  output logic keypad_wake
);

  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] awaddr;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic [NPINS-1:0] latch;
    logic [NPINS-1:0] s1;
    logic [NPINS-1:0] s2;
    logic [NPINS-1:0] s3;
    logic [NPINS-1:0] lvl;
    logic [15:0] mode_a;
    logic [15:0] mode_b;
    logic [7:0] p2_misc;
    logic [7:0] p2_second;
    logic [7:0] kp_en;
    logic kb_flag;
    logic kb_ie;
    logic t0_tog;
    logic t1_tog;
    logic [1:0] div_cnt;
    logic clk_div;
    logic init_done;
    logic xtal;
    logic rc;
    logic int_rst;
  } ppk_top_st_t;

  ppk_top_st_t st;
  ppk_top_st_t next_st;

  ppk_drv_if drv_bus();

  // ==========================================================
  // address decode, shared by the read and write paths
  function automatic ppk_reg_t reg_sel(input logic [ADDR_W-1:0] addr);
    ppk_reg_t r;
    r = REG_NONE;
    if (addr[1:0] == 2'h0) begin
      case (addr[ADDR_W-1:2])
        IDX_P0: r = REG_P0;
        IDX_P0MA: r = REG_P0MA;
        IDX_P0MB: r = REG_P0MB;
        IDX_KPEN: r = REG_KPEN;
        IDX_P1: r = REG_P1;
        IDX_P1MA: r = REG_P1MA;
        IDX_P1MB: r = REG_P1MB;
        IDX_P2: r = REG_P2;
        IDX_AUX: r = REG_AUX;
        IDX_P2MISC: r = REG_P2MISC;
        IDX_P2MB: r = REG_P2MB;
        default: r = REG_NONE;
      endcase
    end
    return r;
  endfunction

  // ==========================================================
  // combinational decode of pin controls from registered state
  logic kb_set;
  logic clkout_on;
  logic [NPINS-1:0] eff_a;
  logic [NPINS-1:0] eff_b;
  logic [NPINS-1:0] eff_val;

  // keypad: any enabled port0 pin seen low
  assign kb_set = |(st.kp_en & ~st.lvl[7:0]);
  // clock out needs the rc oscillator, not a crystal
  assign clkout_on = st.p2_misc[BIT_CLKO] & st.rc & !st.xtal;

  // effective output values and modes after fixed-function overrides
  always_comb begin
    eff_val = st.latch;
    // port2 pins 0,1 take their modes from the two port2 registers
    eff_a = {6'h00, st.p2_misc[1:0], st.mode_a};
    eff_b = {6'h00, st.p2_second[1:0], st.mode_b};
    if (st.p2_misc[BIT_TOG1]) begin
      eff_val[PIN_T1_TOG] = st.t1_tog;
    end
    if (st.p2_misc[BIT_TOG0]) begin
      eff_val[PIN_T0_TOG] = st.t0_tog;
    end
    // these two pins are open drain whatever the mode registers say
    {eff_a[PIN_OD_A], eff_b[PIN_OD_A]} = MODE_OD;
    {eff_a[PIN_OD_B], eff_b[PIN_OD_B]} = MODE_OD;
    {eff_a[PIN_RST], eff_b[PIN_RST]} = MODE_INPUT;
    if (st.xtal) begin
      {eff_a[PIN_X2], eff_b[PIN_X2]} = MODE_INPUT;
      {eff_a[PIN_X1], eff_b[PIN_X1]} = MODE_INPUT;
    end else if (clkout_on) begin
      // push-pull so both edges of the clock are driven hard
      {eff_a[PIN_X2], eff_b[PIN_X2]} = MODE_PUSH;
      eff_val[PIN_X2] = st.clk_div;
    end
  end

  assign drv_bus.out_val = eff_val;
  assign drv_bus.mode_a = eff_a;
  assign drv_bus.mode_b = eff_b;
  assign drv_bus.pin_lvl = st.lvl;

  ppk_pin_drv u_drv (
    .clock(clock),
    .rst_n(rst_n),
    .bus(drv_bus.drv)
  );

  // ==========================================================
  // pad side outputs
  assign pin_out = drv_bus.pu_strong;
  assign pin_oe = drv_bus.pu_strong | drv_bus.pull_down;
  assign pu_very_weak = drv_bus.pu_very_weak;
  assign pu_weak = drv_bus.pu_weak;

  // input enables: crystal pins and an external-reset pin are cut off
  always_comb begin
    pin_in_en = {NPINS{1'b1}};
    pin_in_en[PIN_RST] = st.int_rst;
    if (st.xtal) begin
      pin_in_en[PIN_X2] = 1'b0;
      pin_in_en[PIN_X1] = 1'b0;
    end
    pin_schmitt = {{8{st.p2_misc[BIT_SCH2]}}, {8{st.p2_misc[BIT_SCH1]}},
      {8{st.p2_misc[BIT_SCH0]}}};
    pin_schmitt[PIN_OD_A] = 1'b1;
    pin_schmitt[PIN_OD_B] = 1'b1;
    pin_schmitt[PIN_RST] = 1'b1;
  end

  // interrupt and wake
  assign keypad_irq = st.kb_flag & st.kb_ie;
  // wake also looks at raw port0 so a stopped clock can still be left;
  // this is the only path that bypasses the synchroniser
  assign keypad_wake = st.kb_ie & (st.kb_flag | (|(st.kp_en & ~pin_in[7:0])));

  // ==========================================================
  // axi4-lite handshakes
  assign s_axi_awready = !st.aw_got & !st.bvalid;
  assign s_axi_wready = !st.w_got & !st.bvalid;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = !st.rvalid;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rresp = st.rresp;
  assign s_axi_rdata = {24'h000000, st.rdata};

  // ==========================================================
  // next-state logic
  always_comb begin
    ppk_reg_t wsel;
    ppk_reg_t rsel;
    logic do_wr;
    logic aux_wr;
    wsel = reg_sel(st.awaddr);
    rsel = reg_sel(s_axi_araddr);
    do_wr = st.aw_got & st.w_got;
    aux_wr = 1'b0;
    next_st = st;

    // pin synchroniser: stage one feeds only stage two
    next_st.s1 = pin_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    // a change is taken once stages two and three agree
    next_st.lvl = (st.s2 & st.s3) | (st.lvl & (st.s2 | st.s3));

    // write address and data, accepted in either order
    if (s_axi_awvalid && s_axi_awready) begin
      next_st.aw_got = 1'b1;
      next_st.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_st.w_got = 1'b1;
      next_st.wdata = s_axi_wdata[7:0];
      next_st.wstrb0 = s_axi_wstrb[0];
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end

    // register write once both halves are in
    if (do_wr) begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = (wsel == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
      // upper lanes hold nothing, so only lane zero counts
      if (st.wstrb0) begin
        case (wsel)
          REG_P0: next_st.latch[7:0] = st.wdata;
          REG_P1: next_st.latch[15:8] = st.wdata;
          REG_P2: next_st.latch[23:16] = st.wdata;
          REG_P0MA: next_st.mode_a[7:0] = st.wdata;
          REG_P0MB: next_st.mode_b[7:0] = st.wdata;
          REG_P1MA: next_st.mode_a[15:8] = st.wdata;
          REG_P1MB: next_st.mode_b[15:8] = st.wdata;
          REG_KPEN: next_st.kp_en = st.wdata;
          REG_P2MISC: next_st.p2_misc = st.wdata;
          REG_P2MB: next_st.p2_second = st.wdata;
          REG_AUX: begin
            aux_wr = 1'b1;
            next_st.kb_ie = st.wdata[AUX_KBIE];
          end
          default: ;
        endcase
      end
    end

    // keypad flag: written by software, set by hardware, set wins
    if (aux_wr) begin
      next_st.kb_flag = st.wdata[AUX_KFLAG];
    end
    if (kb_set) begin
      next_st.kb_flag = 1'b1;
    end

    // read: port offsets return the synchronised pin levels
    if (s_axi_arvalid && s_axi_arready) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = RESP_OKAY;
      case (rsel)
        REG_P0: next_st.rdata = st.lvl[7:0];
        REG_P1: next_st.rdata = st.lvl[15:8];
        REG_P2: next_st.rdata = st.lvl[23:16];
        REG_P0MA: next_st.rdata = st.mode_a[7:0];
        REG_P0MB: next_st.rdata = st.mode_b[7:0];
        REG_P1MA: next_st.rdata = st.mode_a[15:8];
        REG_P1MB: next_st.rdata = st.mode_b[15:8];
        REG_KPEN: next_st.rdata = st.kp_en;
        REG_P2MISC: next_st.rdata = st.p2_misc;
        REG_P2MB: next_st.rdata = st.p2_second;
        REG_AUX: begin
          next_st.rdata = REG_RESET;
          next_st.rdata[AUX_KFLAG] = st.kb_flag;
          next_st.rdata[AUX_KBIE] = st.kb_ie;
        end
        default: begin
          next_st.rdata = REG_RESET;
          next_st.rresp = RESP_SLVERR;
        end
      endcase
    end else if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end

    // timer toggles: one flip per overflow halves the rate
    if (timer1_ovf && st.p2_misc[BIT_TOG1]) begin
      next_st.t1_tog = !st.t1_tog;
    end
    if (timer0_ovf && st.p2_misc[BIT_TOG0]) begin
      next_st.t0_tog = !st.t0_tog;
    end

    // clock out divider: half period of three clocks gives clock / 6;
    // not gated by idle, only by the enable bit, the rc strap and the crystal strap
    if (!clkout_on) begin
      next_st.div_cnt = 2'h0;
      next_st.clk_div = 1'b0;
    end else if (st.div_cnt == CLKOUT_HALF - 2'h1) begin
      next_st.div_cnt = 2'h0;
      next_st.clk_div = !st.clk_div;
    end else begin
      next_st.div_cnt = st.div_cnt + 2'h1;
    end

    // first clock after reset: capture straps, load latch level;
    // takes precedence over a bus write landing in the same cycle
    if (!st.init_done) begin
      next_st.init_done = 1'b1;
      next_st.latch = {NPINS{port_reset_level_sel}};
      next_st.xtal = osc_crystal_sel;
      next_st.rc = osc_rc_sel;
      next_st.int_rst = int_reset_sel;
    end
  end

  // ==========================================================
  // state register; modes clear to quasi so reset-high pins are weak
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule

// ### verification/ppk_pad_model.sv
// board model: pull-up resistors and key switches on every pin
// assumes pin_oe high means the block drives pin_out onto the pad
`timescale 1ns/100ps
module ppk_pad_model
  import ppk_pkg::*;
(
  input wire logic [NPINS-1:0] pin_out,
  input wire logic [NPINS-1:0] pin_oe,
  input wire logic [NPINS-1:0] key_low,
  output logic [NPINS-1:0] pin_in
);
  // ==========================================================
  // pad level
  // a closed key sinks more than the weak pull-ups can source, so it wins
  // unless the block drives; an idle pad rests high on the board resistor
  always_comb begin
    for (int i = 0; i < NPINS; i++) begin
      if (pin_oe[i]) begin
        pin_in[i] = pin_out[i];
      end else begin
        pin_in[i] = !key_low[i];
      end
    end
  end
endmodule

// ### verification/ppk_port_sva.sv
// concurrent checks on the ports of the port pin and keypad block
// assumes it is bound into ppk_port_top and sees only its ports
`timescale 1ns/100ps
module ppk_port_sva
  import ppk_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic s_axi_bvalid,
  input wire logic [NPINS-1:0] pin_out,
  input wire logic [NPINS-1:0] pin_oe,
  input wire logic [NPINS-1:0] pu_very_weak,
  input wire logic [NPINS-1:0] pu_weak,
  input wire logic [NPINS-1:0] pin_in_en,
  input wire logic [NPINS-1:0] pin_schmitt,
  input wire logic osc_crystal_sel,
  input wire logic keypad_irq,
  input wire logic keypad_wake
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // helper history: strong pull-up on quasi pins, edges since reset
  logic [NPINS-1:0] qs;
  logic [NPINS-1:0] qs_d;
  logic [NPINS-1:0] qs_d2;
  logic [1:0] up;
  assign qs = pin_out & pu_very_weak;
  // straps settle a few edges after release, so wait for up to saturate
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      qs_d <= '0;
      qs_d2 <= '0;
      up <= 2'h0;
    end else begin
      qs_d <= qs;
      qs_d2 <= qs_d;
      if (up != 2'h3) up <= up + 2'h1;
    end
  end
  // ==========================================================
  // pad drive and keypad relations
  a_weak_needs_latch: assert property ((pu_weak & ~pu_very_weak) == '0)
    else $error("weak pull-up on without very weak pull-up");
  a_pulldown_excl: assert property ((pin_oe & ~pin_out & (pu_very_weak | pu_weak)) == '0)
    else $error("pull-up on while pulldown drives");
  a_pulse_max_two: assert property ((qs & qs_d & qs_d2) == '0)
    else $error("strong pull-up longer than two clocks");
  a_pulse_min_two: assert property ((qs_d & ~qs_d2 & ~qs) == '0)
    else $error("strong pull-up shorter than two clocks");
  a_fixed_od_pins: assert property (pin_out[PIN_OD_B:PIN_OD_A] == 2'h0
    && (pu_very_weak[PIN_OD_B:PIN_OD_A] | pu_weak[PIN_OD_B:PIN_OD_A]) == 2'h0)
    else $error("fixed open drain pin pulls up");
  a_fixed_schmitt: assert property (pin_schmitt[PIN_OD_A] && pin_schmitt[PIN_OD_B]
    && pin_schmitt[PIN_RST]) else $error("fixed pin lost schmitt input");
  a_crystal_pins_off: assert property ((up == 2'h3 && osc_crystal_sel) |->
    pin_in_en[PIN_X1:PIN_X2] == 2'h0 && pin_oe[PIN_X1:PIN_X2] == 2'h0)
    else $error("crystal pins still enabled");
  a_irq_wakes: assert property (keypad_irq |-> keypad_wake)
    else $error("pending keypad interrupt without wake");
  a_flag_sticky: assert property ($fell(keypad_irq) |-> $rose(s_axi_bvalid))
    else $error("keypad interrupt dropped without a register write");
endmodule

bind ppk_port_top ppk_port_sva chk_u (.clock(clock), .rst_n(rst_n),
  .s_axi_bvalid(s_axi_bvalid), .pin_out(pin_out), .pin_oe(pin_oe),
  .pu_very_weak(pu_very_weak), .pu_weak(pu_weak), .pin_in_en(pin_in_en),
  .pin_schmitt(pin_schmitt), .osc_crystal_sel(osc_crystal_sel),
  .keypad_irq(keypad_irq), .keypad_wake(keypad_wake));

// ### verification/tb_top.sv
// register-level bench of the port pin and keypad block
// assumes the board model on the pins and an axi4-lite master here
`timescale 1ns/100ps
module tb_top;
  import ppk_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic [ADDR_W-1:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq, wake;
  logic [1:0] bresp, rresp, last_bresp;
  logic [31:0] rdata;
  logic [NPINS-1:0] pin_in, pin_out, pin_oe, pu_vw, pu_wk, in_en, schm;
  logic [NPINS-1:0] key_low = '0;
  logic t0 = 1'b0, t1 = 1'b0, lvl_sel = 1'b1, xtal = 1'b0;
  int fails = 0;
  int samples_checked = 0;

  ppk_port_top dut_u (.clock(clock), .rst_n(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pu_very_weak(pu_vw), .pu_weak(pu_wk), .pin_in_en(in_en), .pin_schmitt(schm),
    .timer0_ovf(t0), .timer1_ovf(t1), .port_reset_level_sel(lvl_sel),
    .osc_crystal_sel(xtal), .osc_rc_sel(1'b1), .int_reset_sel(1'b1),
    .keypad_irq(irq), .keypad_wake(wake));
  ppk_pad_model pad_u (.pin_out(pin_out), .pin_oe(pin_oe), .key_low(key_low),
    .pin_in(pin_in));

  // ==========================================================
  // clock, compare and bus tasks
  always #4 clock = ~clock;

  function automatic logic [ADDR_W-1:0] adr(input logic [IDX_W-1:0] idx);
    return {idx, 2'b00};
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  // each bus task starts one edge on so no strobe is assigned twice at a step
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    int n;
    @(posedge clock);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    last_bresp = bresp;
    bready <= 1'b0;
    if (n == 50) fails++;
  endtask

  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rready <= 1'b0;
    if (n == 50) fails++;
    check(rdata, d);
    check(32'(rresp), 32'(r));
  endtask

  task automatic do_reset(input logic lvl, input logic xt);
    rst_n <= 1'b0;
    lvl_sel <= lvl;
    xtal <= xt;
    cyc(20);
    rst_n <= 1'b1;
    cyc(3);
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // watchdog, far above the few hundred cycles the tests need
  initial begin
    cyc(20000);
    fails++;
    tally_and_finish();
  end

  // ==========================================================
  // test sequence
  initial begin
    logic [1:0] m;
    logic [1:0] p;
    logic q;
    int k;
    int n;
    int h;
    do_reset(1'b1, 1'b0);
    rchk(adr(IDX_KPEN), 32'h0, RESP_OKAY);
    rchk(adr(IDX_P2MISC), 32'h0, RESP_OKAY);
    check(32'({pin_oe[0], pu_vw[0], in_en[PIN_RST]}), 32'h3);
    // key on pin 3 against the weak pull-up; sync delay first
    key_low[3] <= 1'b1;
    cyc(2);
    check(32'(pu_wk[3]), 32'h1);
    cyc(6);
    check(32'({pu_wk[3], pu_vw[3]}), 32'h1);
    rchk(adr(IDX_P0), 32'hF7, RESP_OKAY);
    key_low[3] <= 1'b0;
    cyc(8);
    check(32'(pu_wk[3]), 32'h1);
    // every mode with latch 0 then 1; count strong drive cycles after rise
    for (k = 0; k < 8; k++) begin
      m = 2'(k >> 1);
      wr(adr(IDX_P0MA), {7'h0, m[1]});
      wr(adr(IDX_P0MB), {7'h0, m[0]});
      wr(adr(IDX_P0), {7'h7F, k[0]});
      n = 0;
      repeat (6) begin
        @(posedge clock);
        n += 32'(pin_out[0]);
      end
      check(32'(n), k[0] ? (m == MODE_PUSH ? 6 : (m == MODE_QUASI ? 2 : 0)) : 0);
      check(32'({pin_oe[0], pin_out[0], pu_vw[0]}), 32'({k[0] ? m == MODE_PUSH : m != MODE_INPUT,
        k[0] && m == MODE_PUSH, k[0] && m == MODE_QUASI}));
    end
    wr(adr(IDX_P0MA), 8'h00);
    wr(adr(IDX_P0MB), 8'h00);
    // port1 all input only: fixed pins stay open drain
    wr(adr(IDX_P1MA), 8'hFF);
    wr(adr(IDX_P1MB), 8'h00);
    wr(adr(IDX_P1), 8'h00);
    cyc(2);
    check(32'({pin_oe[PIN_OD_B:PIN_OD_A], pin_oe[8]}), 32'h6);
    wr(adr(IDX_P1), 8'hFF);
    // one schmitt select bit per port
    for (k = 0; k < 3; k++) begin
      wr(adr(IDX_P2MISC), 8'(8'h20 << k));
      cyc(1);
      check(32'({schm[16], schm[8], schm[0]}), 32'(3'h1 << k));
    end
    // timer overflow pulses toggle both assigned pins
    wr(adr(IDX_P2MISC), 8'h0C);
    cyc(2);
    for (k = 0; k < 4; k++) begin
      p = {pin_oe[PIN_T0_TOG], pu_vw[PIN_T1_TOG]};
      t0 <= 1'b1;
      t1 <= 1'b1;
      @(posedge clock);
      t0 <= 1'b0;
      t1 <= 1'b0;
      cyc(4);
      check(32'({pin_oe[PIN_T0_TOG], pu_vw[PIN_T1_TOG]}), 32'(p ^ 2'h3));
    end
    // clock out: 4 rises and 12 high cycles in 24
    wr(adr(IDX_P2MISC), 8'h10);
    cyc(4);
    n = 0;
    h = 0;
    q = pin_out[PIN_X2];
    repeat (24) begin
      @(posedge clock);
      if (pin_out[PIN_X2] && !q) n++;
      h += 32'(pin_out[PIN_X2]);
      q = pin_out[PIN_X2];
    end
    check(32'({8'(n), 8'(h), pin_oe[PIN_X2]}), 32'({8'h04, 8'h0C, 1'b1}));
    wr(adr(IDX_P2MISC), 8'h00);
    // keypad: only enabled pins raise the sticky flag
    wr(adr(IDX_KPEN), 8'h04);
    rchk(adr(IDX_KPEN), 32'h4, RESP_OKAY);
    wr(adr(IDX_AUX), 8'h01);
    key_low[5] <= 1'b1;
    cyc(8);
    check(32'({irq, wake}), 32'h0);
    key_low[2] <= 1'b1;
    cyc(8);
    check(32'({irq, wake}), 32'h3);
    key_low <= '0;
    cyc(8);
    check(32'(irq), 32'h1);
    rchk(adr(IDX_AUX), 32'h3, RESP_OKAY);
    wr(adr(IDX_AUX), 8'h01);
    cyc(2);
    check(32'(irq), 32'h0);
    // unmapped place answers with an error
    wr(10'h3FC, 8'h5A);
    check(32'(last_bresp), 32'(RESP_SLVERR));
    rchk(10'h3FC, 32'h0, RESP_SLVERR);
    // second reset: low latch level and crystal oscillator
    do_reset(1'b0, 1'b1);
    check(32'({in_en[PIN_X1:PIN_X2], pin_oe[PIN_X1:PIN_X2]}), 32'h0);
    check(32'({pin_oe[0], pin_out[0], pu_vw[0]}), 32'h4);
    // crystal checker arms only once straps have settled
    cyc(2);
    tally_and_finish();
  end
endmodule
